// File: rtl/fsc_cmd_logic.v
// Command and mode logic of a serial NOR flash: power-down, status,
// quad enable, continuous quad read, four-wire command mode, table read.
// Assumes SPI pins are synchronous to i_clk and far slower than it.
`timescale 1ns/1ps
`include "fsc_consts.vh"

// Contract
// - Instruction ABh releases the device from deep power-down.
// - After release wait (2+1) x 1 us before the next operation.
// - Instruction 05h returns status one; bit 0 shows operation in progress.
// - Quad enable is bit 1 of status two, read by instruction 35h.
// - Instruction 01h with two bytes loads quad enable from second byte bit 1.
// - Quad enable high disables hold and write-protect pin functions.
// - Mode byte with upper nibble A keeps continuous quad read; needs quad enable.
// - Mode byte 00h ends continuous quad read after the current read.
// - All ones on four lanes for 8 clocks ends continuous quad read.
// - With quad enable set, 38h moves all later phases to four lanes.
// - FFh or reset sequence 66h then 99h leaves four-wire command mode.
// - Only 3-byte addresses; 4-byte addressing is not supported.
// - Table bytes 64h-67h return dword 5C_D5_A2_F7, low byte first.
// - Table bytes 68h-6Bh return dword FF_DD_F6_19, low byte first.
// - Table bytes 6Ch-6Fh return dword 80_C0_30_E8, low byte first.
// - Soft reset acts only when 66h is immediately followed by 99h.
// - Inputs sampled on rising clock edges, outputs change on falling edges.
module fsc_cmd_logic #(
   parameter CLK_NS = 25                      // System clock period in ns
) (
   input  wire       i_clk,                   // System clock
   input  wire       i_rstn,                  // Asynchronous reset, active low
   input  wire       i_sck,                   // Serial clock from host
   input  wire       i_cs_n,                  // Chip select, active low
   input  wire [3:0] i_lane_in,               // Sampled four_data_lanes
   output reg  [3:0] o_lane_out,              // Driven four_data_lanes
   output reg  [3:0] o_lane_oe_n,             // Lane output enable, low drives
   output reg        o_hold_en,               // Hold function active
   output reg        o_wp_en,                 // Write-protect function active
   input  wire [1:0] i_addr,                  // Register address
   input  wire [7:0] i_wdata,                 // Register write data
   input  wire       i_wr,                    // Register write strobe
   input  wire       i_rd,                    // Register read strobe
   output reg  [7:0] o_rdata                  // Register read data
);

   // ==========================================================
   // States and derived counts
   localparam [2:0] ST_CMD   = 3'd0;
   localparam [2:0] ST_ADDR  = 3'd1;
   localparam [2:0] ST_MODE  = 3'd2;
   localparam [2:0] ST_DUMMY = 3'd3;
   localparam [2:0] ST_OUT   = 3'd4;
   localparam [2:0] ST_WIN   = 3'd5;
   localparam [2:0] ST_SKIP  = 3'd6;

   localparam integer REC_CYC_I = (`FSC_PD_DELAY_NS + CLK_NS - 1) / CLK_NS;
   localparam [7:0]   REC_CYC   = REC_CYC_I[7:0];

   // Parameter table byte lookup
   function [7:0] fsc_table;
      input [23:0] addr;
      reg   [31:0] dw;
      begin
         dw = 32'h0000_0000;
         fsc_table = `FSC_TABLE_BLANK;
         if (addr[23:8] == 16'h0000) begin
            case (addr[7:2])
               `FSC_DW14_IDX: dw = `FSC_DW14;
               `FSC_DW15_IDX: dw = `FSC_DW15;
               `FSC_DW16_IDX: dw = `FSC_DW16;
               default:       dw = {4{`FSC_TABLE_BLANK}};
            endcase
            fsc_table = dw[{addr[1:0], 3'b000} +: 8];
         end
      end
   endfunction

   // ==========================================================
   // State registers
   reg        sck_q;
   reg        cs_n_q;
   reg [2:0]  st_q;
   reg [7:0]  shift_q;
   reg [3:0]  cnt_q;
   reg [3:0]  dcnt_q;
   reg [1:0]  bcnt_q;
   reg [7:0]  cmd_q;
   reg [23:0] addr_q;
   reg [7:0]  out_q;
   reg        quad_q;
   reg [7:0]  status2_q;
   reg        busy_q;
   reg        pd_q;
   reg [7:0]  rec_q;
   reg        qpi_q;
   reg        cont_q;
   reg        cont_keep_q;
   reg        mode_seen_q;
   reg        rst_en_q;
   reg [3:0]  ones_q;

   // ==========================================================
   // Edge detect and lane shifting
   wire       rise  = i_sck & ~sck_q & ~i_cs_n;
   wire       fall  = ~i_sck & sck_q & ~i_cs_n;
   wire       start = cs_n_q & ~i_cs_n;
   wire       stop  = ~cs_n_q & i_cs_n;
   wire       quad_en = status2_q[`FSC_QUAD_EN_BIT];
   wire       asleep = pd_q | (rec_q != 8'h00);

   reg [7:0]  shift_nx;
   reg [3:0]  cnt_nx;
   reg        byte_done;

   // Next shift value and bit count
   always @* begin
      if (quad_q) begin
         shift_nx = {shift_q[3:0], i_lane_in};
         cnt_nx   = cnt_q + 4'h4;
      end else begin
         shift_nx = {shift_q[6:0], i_lane_in[0]};
         cnt_nx   = cnt_q + 4'h1;
      end
      byte_done = rise & (cnt_nx == `FSC_BYTE_BITS);
   end

   // ==========================================================
   // Serial side: frames, decode and modes
   always @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         sck_q       <= 1'b0;
         cs_n_q      <= 1'b1;
         st_q        <= ST_CMD;
         shift_q     <= 8'h00;
         cnt_q       <= 4'h0;
         dcnt_q      <= 4'h0;
         bcnt_q      <= 2'h0;
         cmd_q       <= 8'h00;
         addr_q      <= 24'h00_0000;
         out_q       <= 8'h00;
         quad_q      <= 1'b0;
         status2_q   <= `FSC_STATUS2_RST;
         pd_q        <= 1'b0;
         rec_q       <= 8'h00;
         qpi_q       <= 1'b0;
         cont_q      <= 1'b0;
         cont_keep_q <= 1'b0;
         mode_seen_q <= 1'b0;
         rst_en_q    <= 1'b0;
         ones_q      <= 4'h0;
         o_lane_out  <= 4'h0;
         o_lane_oe_n <= 4'hF;
      end else begin
         sck_q  <= i_sck;
         cs_n_q <= i_cs_n;
         // Recovery timer after release
         if (rec_q != 8'h00) begin
            rec_q <= rec_q - 8'h01;
         end
         if (start) begin
            cnt_q       <= 4'h0;
            bcnt_q      <= 2'h0;
            ones_q      <= 4'h0;
            mode_seen_q <= 1'b0;
            if (cont_q && !asleep) begin
               st_q   <= ST_ADDR;
               cmd_q  <= `FSC_OP_QUAD_IO_READ;
               quad_q <= 1'b1;
            end else begin
               st_q   <= ST_CMD;
               quad_q <= qpi_q;
            end
         end else if (stop) begin
            st_q        <= ST_CMD;
            o_lane_oe_n <= 4'hF;
            // Mode byte decision applies when the read ends
            if (cmd_q == `FSC_OP_QUAD_IO_READ && mode_seen_q) begin
               cont_q <= cont_keep_q;
            end
         end else if (rise) begin
            shift_q <= shift_nx;
            cnt_q   <= byte_done ? 4'h0 : cnt_nx;
            // Ones on all lanes for eight clocks leave continuous read
            if (cont_q && st_q != ST_OUT) begin
               if (i_lane_in == `FSC_LANES_ONES) begin
                  ones_q <= ones_q + 4'h1;
                  if (ones_q + 4'h1 == `FSC_ONES_CLOCKS) begin
                     cont_q <= 1'b0;
                     st_q   <= ST_SKIP;
                  end
               end else begin
                  ones_q <= 4'h0;
               end
            end
            case (st_q)
               ST_CMD: begin
                  if (byte_done) begin
                     st_q     <= ST_SKIP;
                     cmd_q    <= shift_nx;
                     rst_en_q <= 1'b0;
                     if (asleep) begin
                        // Only release is honoured while asleep
                        if (pd_q && shift_nx == `FSC_OP_PD_RELEASE) begin
                           pd_q  <= 1'b0;
                           rec_q <= REC_CYC;
                        end
                     end else begin
                        case (shift_nx)
                           `FSC_OP_READ_SR1: begin
                              st_q  <= ST_OUT;
                              out_q <= {7'h00, busy_q};
                           end
                           `FSC_OP_READ_STATUS2: begin
                              st_q  <= ST_OUT;
                              out_q <= status2_q;
                           end
                           `FSC_OP_WRITE_SR: st_q <= busy_q ? ST_SKIP : ST_WIN;
                           `FSC_OP_READ_TABLE: st_q <= ST_ADDR;
                           `FSC_OP_QUAD_IO_READ: begin
                              if (quad_en) begin
                                 st_q   <= ST_ADDR;
                                 quad_q <= 1'b1;
                              end
                           end
                           `FSC_OP_QPI_ENTER: begin
                              if (quad_en) begin
                                 qpi_q <= 1'b1;
                              end
                           end
                           `FSC_OP_QPI_EXIT: qpi_q <= 1'b0;
                           `FSC_OP_RST_ENABLE: rst_en_q <= 1'b1;
                           `FSC_OP_RST: begin
                              if (rst_en_q) begin
                                 qpi_q  <= 1'b0;
                                 cont_q <= 1'b0;
                              end
                           end
                           `FSC_OP_PD_ENTER: pd_q <= ~busy_q;
                           default: st_q <= ST_SKIP;
                        endcase
                     end
                  end
               end
               ST_ADDR: begin
                  if (byte_done) begin
                     addr_q <= {addr_q[15:0], shift_nx};
                     bcnt_q <= bcnt_q + 2'h1;
                     // Three address bytes only
                     if (bcnt_q == `FSC_ADDR_BYTES) begin
                        dcnt_q <= 4'h0;
                        if (cmd_q == `FSC_OP_QUAD_IO_READ) begin
                           st_q <= ST_MODE;
                        end else begin
                           st_q <= ST_DUMMY;
                        end
                     end
                  end
               end
               ST_MODE: begin
                  if (byte_done) begin
                     mode_seen_q <= 1'b1;
                     // Upper nibble A keeps the mode; 00h or anything else ends it
                     cont_keep_q <= (shift_nx[7:4] == `FSC_MODE_KEEP_NIB) && quad_en;
                     if (shift_nx == `FSC_MODE_EXIT_BYTE) begin
                        cont_keep_q <= 1'b0;
                     end
                     st_q <= ST_DUMMY;
                  end
               end
               ST_DUMMY: begin
                  dcnt_q <= dcnt_q + 4'h1;
                  cnt_q  <= 4'h0;
                  if (dcnt_q + 4'h1 == ((cmd_q == `FSC_OP_QUAD_IO_READ) ? `FSC_QUAD_DUMMY : `FSC_TABLE_DUMMY)) begin
                     st_q <= ST_OUT;
                     if (cmd_q == `FSC_OP_READ_TABLE) begin
                        out_q <= fsc_table(addr_q);
                     end else begin
                        out_q <= `FSC_ARRAY_BLANK;
                     end
                  end
               end
               ST_OUT: begin
                  // Reload next byte after the last bit went out
                  if (byte_done) begin
                     addr_q <= addr_q + 24'h00_0001;
                     if (cmd_q == `FSC_OP_READ_SR1) begin
                        out_q <= {7'h00, busy_q};
                     end else if (cmd_q == `FSC_OP_READ_STATUS2) begin
                        out_q <= status2_q;
                     end else if (cmd_q == `FSC_OP_READ_TABLE) begin
                        out_q <= fsc_table(addr_q + 24'h00_0001);
                     end else begin
                        out_q <= `FSC_ARRAY_BLANK;
                     end
                  end
               end
               ST_WIN: begin
                  if (byte_done) begin
                     bcnt_q <= bcnt_q + 2'h1;
                     // Second byte is status two, quad enable in bit 1
                     if (bcnt_q == 2'h1) begin
                        status2_q <= shift_nx;
                        st_q  <= ST_SKIP;
                     end
                  end
               end
               ST_SKIP: begin
                  cnt_q <= 4'h0;
               end
               default: begin
                  st_q <= ST_SKIP;
               end
            endcase
         end else if (fall && st_q == ST_OUT) begin
            // Present output bits on the falling edge
            if (quad_q) begin
               o_lane_out  <= out_q[7:4];
               o_lane_oe_n <= 4'h0;
               out_q       <= {out_q[3:0], 4'h0};
            end else begin
               o_lane_out  <= {2'b00, out_q[7], 1'b0};
               o_lane_oe_n <= 4'b1101;
               out_q       <= {out_q[6:0], 1'b0};
            end
         end
      end
   end

   // ==========================================================
   // Pin function gating by quad enable
   always @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_hold_en <= 1'b1;
         o_wp_en   <= 1'b1;
      end else begin
         o_hold_en <= ~quad_en;
         o_wp_en   <= ~quad_en;
      end
   end

   // ==========================================================
   // Register port: busy control and state readback
   always @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         busy_q  <= 1'b0;
         o_rdata <= 8'h00;
      end else begin
         if (i_wr && i_addr == `FSC_REG_CTRL) begin
            busy_q <= i_wdata[`FSC_BUSY_BIT];
         end
         if (i_rd) begin
            case (i_addr)
               `FSC_REG_CTRL:  o_rdata <= {7'h00, busy_q};
               `FSC_REG_STATUS2: o_rdata <= status2_q;
               `FSC_REG_STATE: o_rdata <= {4'h0, pd_q, rec_q != 8'h00, qpi_q, cont_q};
               default:        o_rdata <= 8'h00;
            endcase
         end else begin
            o_rdata <= 8'h00;
         end
      end
   end

endmodule

// File: inc/fsc_consts.vh
// Constants for the serial flash command and mode logic.
// Assumes inclusion by bare name from rtl files; definitions only.
`ifndef FSC_CONSTS_VH
`define FSC_CONSTS_VH

// ==========================================================
// Instruction codes
`define FSC_OP_PD_RELEASE   8'hAB
`define FSC_OP_PD_ENTER     8'hB9
`define FSC_OP_READ_SR1     8'h05
`define FSC_OP_READ_STATUS2 8'h35
`define FSC_OP_WRITE_SR     8'h01
`define FSC_OP_READ_TABLE   8'h5A
`define FSC_OP_QUAD_IO_READ 8'hEB
`define FSC_OP_QPI_ENTER    8'h38
`define FSC_OP_QPI_EXIT     8'hFF
`define FSC_OP_RST_ENABLE   8'h66
`define FSC_OP_RST          8'h99

// ==========================================================
// Mode byte handling
`define FSC_MODE_KEEP_NIB   4'hA
`define FSC_MODE_EXIT_BYTE  8'h00
`define FSC_LANES_ONES      4'hF
`define FSC_ONES_CLOCKS     4'h8

// ==========================================================
// Status field positions and reset values
`define FSC_BUSY_BIT        0
`define FSC_QUAD_EN_BIT     1
`define FSC_STATUS2_RST     8'h00

// ==========================================================
// Power-down recovery: (count + 1) * unit
`define FSC_PD_UNIT_NS      1000
`define FSC_PD_COUNT        2
`define FSC_PD_DELAY_NS     ((`FSC_PD_COUNT + 1) * `FSC_PD_UNIT_NS)

// ==========================================================
// Frame layout
`define FSC_ADDR_BYTES      2'h2
`define FSC_TABLE_DUMMY     4'h8
`define FSC_QUAD_DUMMY      4'h4
`define FSC_BYTE_BITS       4'h8

// ==========================================================
// Parameter table dwords, lowest address carries the low byte
`define FSC_DW14_IDX        6'h19
`define FSC_DW15_IDX        6'h1A
`define FSC_DW16_IDX        6'h1B
`define FSC_DW14            32'h5CD5_A2F7
`define FSC_DW15            32'hFFDD_F619
`define FSC_DW16            32'h80C0_30E8
`define FSC_TABLE_BLANK     8'hFF
`define FSC_ARRAY_BLANK     8'hFF

// ==========================================================
// Local register port map
`define FSC_REG_CTRL        2'h0
`define FSC_REG_STATUS2     2'h1
`define FSC_REG_STATE       2'h2

`endif

// File: verif/fsc_cmd_chk.sv
// Port checker for the flash command and mode logic.
// Assumes one clock domain and an asynchronous active-low reset.
`timescale 1ns/1ps
// ==========================================
// Checker
module fsc_cmd_chk (
   input logic       i_clk,       // System clock
   input logic       i_rstn,      // Reset, active low
   input logic       i_sck,       // Serial clock
   input logic       i_cs_n,      // Chip select, active low
   input logic [3:0] i_lane_in,   // Lane inputs
   input logic [3:0] o_lane_out,  // Lane outputs
   input logic [3:0] o_lane_oe_n, // Lane enables, low drives
   input logic       o_hold_en,   // Hold function
   input logic       o_wp_en,     // Write-protect function
   input logic [1:0] i_addr,      // Register address
   input logic [7:0] i_wdata,     // Write data
   input logic       i_wr,        // Write strobe
   input logic       i_rd,        // Read strobe
   input logic [7:0] o_rdata      // Read data
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rstn);
   // Register access steps
   sequence s_ctrl_wr; i_wr && i_addr == 2'h0; endsequence
   sequence s_ctrl_rd; i_rd && !i_wr && i_addr == 2'h0; endsequence
   sequence s_state_rd; i_rd && i_addr == 2'h2; endsequence
   a_ctrl_busy_back: assert property (s_ctrl_wr ##1 s_ctrl_rd |=> o_rdata[0] == $past(i_wdata[0], 2))
      else $error("busy bit readback wrong");
   a_quad_en_mirror: assert property (i_rd && i_addr == 2'h1 |=> o_rdata[1] == !o_hold_en)
      else $error("quad enable and hold function disagree");
   a_mode_needs_qe: assert property (s_state_rd ##1 (o_rdata[1:0] != 2'h0) |-> !o_hold_en)
      else $error("quad mode active without quad enable");
   a_status_read_only: assert property (i_wr && i_addr == 2'h1 && i_cs_n && $past(i_cs_n) |=> $stable(o_hold_en))
      else $error("status two changed by register write");
   a_hold_wp_pair: assert property (o_hold_en == o_wp_en)
      else $error("hold and write-protect functions differ");
   a_single_lane_oe: assert property (o_hold_en |-> o_lane_oe_n != 4'h0)
      else $error("quad drive while hold function active");
   a_out_on_fall: assert property ($changed(o_lane_out) && !i_cs_n |-> !i_sck)
      else $error("lane output changed while serial clock high");
   a_idle_release: assert property (i_cs_n [*3] |-> o_lane_oe_n == 4'hF)
      else $error("lanes driven while deselected");
   a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
      else $error("read data outside its cycle");
endmodule
bind fsc_cmd_logic fsc_cmd_chk u_chk (.i_clk(i_clk), .i_rstn(i_rstn), .i_sck(i_sck), .i_cs_n(i_cs_n),
   .i_lane_in(i_lane_in), .o_lane_out(o_lane_out), .o_lane_oe_n(o_lane_oe_n), .o_hold_en(o_hold_en),
   .o_wp_en(o_wp_en), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata));

// File: verif/fsc_host_model.sv
// Host SPI controller model: mode 0 clock, chip select and lane drive.
// Assumes tasks are entered just after a rising edge of i_clk.
`timescale 1ns/1ps
// ==========================================
// Host model
module fsc_host_model (
   input  logic       i_clk,   // System clock
   input  logic [3:0] i_lanes, // Resolved lane levels
   output logic       o_sck,   // Serial clock, idles low
   output logic       o_cs_n,  // Chip select, active low
   output logic [3:0] o_lanes  // Host lane drive
);
   // Idle levels, hold and write-protect lanes high
   initial begin
      o_sck = 1'b0;
      o_cs_n = 1'b1;
      o_lanes = 4'hF;
   end
   // Half a serial clock period
   task automatic half();
      repeat (4) @(posedge i_clk);
   endtask
   // Open a frame
   task automatic fb();
      o_cs_n <= 1'b0;
      half();
   endtask
   // One clock with lanes set up before the rise
   task automatic put(input logic [3:0] v);
      o_lanes <= v;
      half();
      o_sck <= 1'b1;
      half();
      o_sck <= 1'b0;
   endtask
   // One clock sampling device data at the rise
   task automatic get(output logic [3:0] v);
      o_lanes <= {2'b11, ~o_lanes[1:0]};
      half();
      o_sck <= 1'b1;
      v = i_lanes;
      half();
      o_sck <= 1'b0;
   endtask
   // Send a byte, most significant first
   task automatic sb(input logic [7:0] b, input logic q);
      if (q) begin
         put(b[7:4]);
         put(b[3:0]);
      end else begin
         for (int i = 7; i >= 0; i--) put({3'b111, b[i]});
      end
   endtask
   // Receive a byte on lane one or on four lanes
   task automatic rb(input logic q, output logic [7:0] b);
      logic [3:0] v;
      for (int i = 0; i < (q ? 2 : 8); i++) begin
         get(v);
         b = q ? {b[3:0], v} : {b[6:0], v[1]};
      end
   endtask
   // Close a frame, released lanes toggle
   task automatic fe();
      half();
      o_cs_n <= 1'b1;
      o_lanes <= {2'b11, ~o_lanes[1:0]};
      half();
      half();
   endtask
endmodule

// File: verif/test_flash_mode_sfdp_command_logic.sv
// Testbench for the flash command and mode logic.
// Assumes the host model and the bound port checker.
`timescale 1ns/1ps
// ==========================================
// Testbench
module test_flash_mode_sfdp_command_logic;
   logic        i_clk, i_rstn, i_wr, i_rd;
   logic [1:0]  i_addr;
   logic [7:0]  i_wdata, d;
   logic [95:0] tbl;
   wire  [7:0]  o_rdata;
   wire  [3:0]  o_lane_out, o_lane_oe_n, host_lanes, lane_lvl;
   wire         o_hold_en, o_wp_en, sck, cs_n;
   int          miscompares, n_compared;
   // Lane level from the device's enables, host drive where the device is not driving
   assign lane_lvl = (o_lane_out & ~o_lane_oe_n) | (host_lanes & o_lane_oe_n);
   fsc_cmd_logic #(.CLK_NS(25)) dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_sck(sck), .i_cs_n(cs_n),
      .i_lane_in(lane_lvl), .o_lane_out(o_lane_out), .o_lane_oe_n(o_lane_oe_n), .o_hold_en(o_hold_en),
      .o_wp_en(o_wp_en), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata));
   fsc_host_model host (.i_clk(i_clk), .i_lanes(lane_lvl), .o_sck(sck), .o_cs_n(cs_n), .o_lanes(host_lanes));
   // Compare and count
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic reg_wr(input logic [1:0] a, input logic [7:0] v);
      i_addr <= a;
      i_wdata <= v;
      i_wr <= 1'b1;
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask
   task automatic reg_rd(input logic [1:0] a, output logic [7:0] v);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_clk);
      i_rd <= 1'b0;
      @(negedge i_clk);
      v = o_rdata;
      @(posedge i_clk);
   endtask
   task automatic st(input logic [7:0] exp);
      reg_rd(2'h2, d);
      chk(d, exp);
   endtask
   task automatic cmd(input logic [7:0] op, input logic q);
      host.fb();
      host.sb(op, q);
      host.fe();
   endtask
   task automatic rd_cmd(input logic [7:0] op, input logic q, input logic [7:0] exp);
      host.fb();
      host.sb(op, q);
      host.rb(q, d);
      host.fe();
      chk(d, exp);
   endtask
   task automatic wr_sr(input logic [7:0] v);
      host.fb();
      host.sb(8'h01, 1'b0);
      host.sb(8'h00, 1'b0);
      host.sb(v, 1'b0);
      host.fe();
   endtask
   // Quad read: address, mode, four dummy clocks, one data byte
   task automatic qread(input logic first, input logic [7:0] mode);
      host.fb();
      if (first) host.sb(8'hEB, 1'b0);
      repeat (3) host.sb(8'h00, 1'b1);
      host.sb(mode, 1'b1);
      repeat (3) host.rb(1'b1, d);
      host.fe();
      chk(d, 8'hFF);
   endtask
   task automatic finish_test();
      $display("compared %0d mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // Clock, 25 ns period
   initial begin
      i_clk = 1'b0;
      forever #12.5 i_clk = ~i_clk;
   end
   // Watchdog
   initial begin
      repeat (60000) @(posedge i_clk);
      miscompares++;
      finish_test();
   end
   // Test sequence
   initial begin
      i_rstn = 1'b0;
      i_wr = 1'b0;
      i_rd = 1'b0;
      i_addr = 2'h0;
      i_wdata = 8'h00;
      miscompares = 0;
      n_compared = 0;
      repeat (20) @(posedge i_clk);
      i_rstn <= 1'b1;
      @(posedge i_clk);
      chk({4'h0, o_lane_oe_n}, 8'h0F);
      chk({6'h00, o_hold_en, o_wp_en}, 8'h03);
      st(8'h00);
      reg_rd(2'h3, d);
      chk(d, 8'h00);
      $display("test reset done");
      reg_wr(2'h0, 8'h01);
      reg_rd(2'h0, d);
      chk(d, 8'h01);
      rd_cmd(8'h05, 1'b0, 8'h01);
      reg_wr(2'h0, 8'h00);
      rd_cmd(8'h05, 1'b0, 8'h00);
      $display("test busy done");
      wr_sr(8'h02);
      rd_cmd(8'h35, 1'b0, 8'h02);
      chk({6'h00, o_hold_en, o_wp_en}, 8'h00);
      wr_sr(8'h00);
      rd_cmd(8'h35, 1'b0, 8'h00);
      chk({6'h00, o_hold_en, o_wp_en}, 8'h03);
      wr_sr(8'h02);
      reg_wr(2'h1, 8'hFD);
      reg_rd(2'h1, d);
      chk(d, 8'h02);
      reg_wr(2'h0, 8'h01);
      wr_sr(8'h00);
      rd_cmd(8'h35, 1'b0, 8'h02);
      reg_wr(2'h0, 8'h00);
      $display("test quad enable done");
      tbl = 96'h80C0_30E8_FFDD_F619_5CD5_A2F7;
      host.fb();
      host.sb(8'h5A, 1'b0);
      host.sb(8'h00, 1'b0);
      host.sb(8'h00, 1'b0);
      host.sb(8'h64, 1'b0);
      host.rb(1'b0, d);
      for (int k = 0; k < 12; k++) begin
         host.rb(1'b0, d);
         chk(d, tbl[8 * k +: 8]);
      end
      host.fe();
      $display("test table done");
      qread(1'b1, 8'hA5);
      st(8'h01);
      qread(1'b0, 8'h00);
      st(8'h00);
      qread(1'b1, 8'hA0);
      st(8'h01);
      host.fb();
      repeat (8) host.put(4'hF);
      host.fe();
      st(8'h00);
      $display("test continuous read done");
      cmd(8'h38, 1'b0);
      st(8'h02);
      rd_cmd(8'h05, 1'b1, 8'h00);
      cmd(8'hFF, 1'b1);
      st(8'h00);
      cmd(8'h38, 1'b0);
      cmd(8'h99, 1'b1);
      st(8'h02);
      cmd(8'h66, 1'b1);
      cmd(8'h99, 1'b1);
      st(8'h00);
      $display("test four-wire done");
      cmd(8'hB9, 1'b0);
      st(8'h08);
      cmd(8'h38, 1'b0);
      st(8'h08);
      cmd(8'hAB, 1'b0);
      st(8'h04);
      cmd(8'h38, 1'b0);
      st(8'h04);
      repeat (130) @(posedge i_clk);
      st(8'h00);
      cmd(8'h38, 1'b0);
      st(8'h02);
      $display("test power-down done");
      finish_test();
   end
endmodule
